// >>> bench/coa_far_model.sv
`timescale 1ns/1ps
module coa_far_model (
  output logic [2:0] pll_clk,
  input wire logic load_in,
  output int load_edges
);
  initial begin
    pll_clk = 3'h0;
    load_edges = 0;
  end
  // unrelated slow periods off the 5 ns grid, so no edge lands on a sampling edge
  always #35.2 pll_clk[0] = ~pll_clk[0];
  always #45.2 pll_clk[1] = ~pll_clk[1];
  always #55.2 pll_clk[2] = ~pll_clk[2];
  // downstream load counts the rising edges it receives
  always @(posedge load_in) load_edges <= load_edges + 1;
endmodule // coa_far_model

// >>> bench/coa_top_asserts.sv
`timescale 1ns/1ps
module coa_top_asserts #(
  parameter int NUM_PLL = coa_pkg::NUM_PLL,
  parameter int NUM_OUT = coa_pkg::NUM_OUT
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [coa_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [coa_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic nvm_load_done,
  input wire coa_pkg::coa_status_t status_raw,
  input wire logic output_gate_pin_n,
  input wire coa_pkg::coa_clk_out_t clk_out,
  input wire logic interrupt_out_n,
  input wire logic bootloader_active,
  input wire logic [NUM_PLL+NUM_OUT+NUM_PLL-1:0] power_down,
  input wire logic cascade_active
);
  logic [3:0] since_chg_q;
  logic [5:0] gate_cnt_q;
  coa_pkg::coa_status_t stat_q;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  // quiet time since the last raw status edge, saturating
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      stat_q <= '0;
      since_chg_q <= 4'hF;
    end else begin
      stat_q <= status_raw;
      if (status_raw != stat_q) since_chg_q <= 4'h0;
      else if (since_chg_q != 4'hF) since_chg_q <= since_chg_q + 4'h1;
    end
  end
  // gate pin high time; long enough covers sync plus one output period
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) gate_cnt_q <= 6'h0;
    else if (!output_gate_pin_n) gate_cnt_q <= 6'h0;
    else if (gate_cnt_q != 6'h3F) gate_cnt_q <= gate_cnt_q + 6'h1;
  end
  property p_intr_cause;
    $fell(interrupt_out_n) |-> since_chg_q <= 4'h8;
  endproperty
  a_intr_cause: assert property (p_intr_cause)
    else $error("interrupt fell without a status edge");
  property p_intr_hold;
    // the sticky bit and the pin are both registered, so a clear shows two cycles after the write
    !interrupt_out_n && !reg_wr && !$past(reg_wr) |=> !interrupt_out_n;
  endproperty
  a_intr_hold: assert property (p_intr_hold)
    else $error("interrupt dropped without a sticky clear");
  property p_intr_clear;
    reg_wr && reg_addr == coa_pkg::REG_STICKY && reg_wdata[11:0] == 12'hFFF
      && nvm_load_done && since_chg_q >= 4'hC |-> ##[1:3] interrupt_out_n;
  endproperty
  a_intr_clear: assert property (p_intr_clear)
    else $error("interrupt still low after sticky clear");
  property p_boot_key;
    reg_wr && reg_addr == coa_pkg::REG_BOOT && reg_wdata == coa_pkg::BOOT_KEY
      && nvm_load_done |-> ##[1:3] bootloader_active;
  endproperty
  a_boot_key: assert property (p_boot_key)
    else $error("boot key write did not enter bootloader");
  property p_pwr;
    reg_wr && reg_addr == coa_pkg::REG_PWR && nvm_load_done && !cascade_active
      |-> ##2 power_down == $past(reg_wdata[12:0], 2);
  endproperty
  a_pwr: assert property (p_pwr)
    else $error("power down bits differ from write");
  property p_cascade;
    reg_wr && reg_addr == coa_pkg::REG_CTRL && nvm_load_done
      |-> ##2 cascade_active == $past(reg_wdata[4], 2);
  endproperty
  a_cascade: assert property (p_cascade)
    else $error("cascade flag differs from control write");
  property p_out6_up;
    cascade_active && $past(cascade_active) |-> !power_down[NUM_PLL+coa_pkg::OUT_CASCADE_SRC];
  endproperty
  a_out6_up: assert property (p_out6_up)
    else $error("output 6 powered down while cascading");
  property p_gate;
    gate_cnt_q >= 6'h28 |-> $stable(clk_out);
  endproperty
  a_gate: assert property (p_gate)
    else $error("outputs move while gate pin is high");
  c_intr: cover property (!interrupt_out_n);
  c_boot: cover property (bootloader_active);
  c_gate: cover property (gate_cnt_q >= 6'h28);
  c_casc: cover property (cascade_active);
endmodule // coa_top_asserts

bind coa_top coa_top_asserts #(.NUM_PLL(NUM_PLL), .NUM_OUT(NUM_OUT)) u_chk (
  .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .nvm_load_done(nvm_load_done), .status_raw(status_raw),
  .output_gate_pin_n(output_gate_pin_n), .clk_out(clk_out),
  .interrupt_out_n(interrupt_out_n), .bootloader_active(bootloader_active),
  .power_down(power_down), .cascade_active(cascade_active)
);

// >>> bench/test_clock_output_alarm_control.sv
`timescale 1ns/1ps
module test_clock_output_alarm_control;
  logic clk, sys_rst, reg_wr, reg_rd, nvm_valid, nvm_load_done;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, nvm_word, rd_q;
  logic [15:0] pps_phase_err, pps_phase_offset;
  coa_pkg::coa_status_t status_raw;
  coa_pkg::coa_clk_out_t clk_out;
  logic crystal_ref_loss_alarm, output_gate_pin_n, reset_pin_n, boot_mode_select_n;
  logic interrupt_out_n, pps_pll_lock_loss_pin, bootloader_active, cascade_active;
  logic [2:0] pll_clk;
  logic [12:0] power_down;
  int n_mismatch = 0, check_count = 0, cyc = 0, load_edges, k;
  coa_top uut (
    .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .nvm_word(nvm_word),
    .nvm_valid(nvm_valid), .nvm_load_done(nvm_load_done), .pps_phase_err(pps_phase_err),
    .status_raw(status_raw), .crystal_ref_loss_alarm(crystal_ref_loss_alarm),
    .output_gate_pin_n(output_gate_pin_n), .reset_pin_n(reset_pin_n),
    .boot_mode_select_n(boot_mode_select_n), .pll_clk(pll_clk), .clk_out(clk_out),
    .interrupt_out_n(interrupt_out_n), .pps_pll_lock_loss_pin(pps_pll_lock_loss_pin),
    .bootloader_active(bootloader_active), .pps_phase_offset(pps_phase_offset),
    .power_down(power_down), .cascade_active(cascade_active)
  );
  coa_far_model far (.pll_clk(pll_clk), .load_in(clk_out.true_pin[0]), .load_edges(load_edges));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      print_verdict();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 rd_q = reg_rdata;
  endtask
  task automatic wait_at(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic reset_load();
    sys_rst <= 1'b1;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    // first stored word routes output 0 to pll 1, the rest load as zero
    @(posedge clk) {nvm_valid, nvm_word} <= {1'b1, 32'h0000_0001};
    @(posedge clk) nvm_word <= 32'h0;
    repeat (2) @(posedge clk);
    nvm_valid <= 1'b0;
  endtask
  task automatic t_intr();
    @(posedge clk) status_raw.signal_loss_alarm[0] <= 1'b1;
    wait_at(10);
    chk("intr on change", 32'h0, 32'(interrupt_out_n));
    rd(coa_pkg::REG_LIVE);
    chk("live bits", 32'h200, 32'(rd_q[11:0]));
    @(posedge clk) status_raw.signal_loss_alarm[0] <= 1'b0;
    wait_at(14);
    rd(coa_pkg::REG_STICKY);
    chk("sticky kept", 32'h200, 32'(rd_q[11:0]));
    wr(coa_pkg::REG_STICKY, 32'hFFF);
    wait_at(3);
    chk("intr released", 32'h1, 32'(interrupt_out_n));
    wr(coa_pkg::REG_MASK, 32'hFFF);
    @(posedge clk) status_raw.oof[1] <= 1'b1;
    wait_at(10);
    chk("masked change", 32'h1, 32'(interrupt_out_n));
    @(posedge clk) status_raw.oof[1] <= 1'b0;
    wait_at(14);
    wr(coa_pkg::REG_STICKY, 32'hFFF);
    wr(coa_pkg::REG_MASK, 32'h0);
    $display("test interrupt done");
  endtask
  task automatic t_out();
    wr(coa_pkg::REG_OUT_MODE, 32'h001F_C055);
    wait_at(20);
    for (k = 0; k < 8; k++) begin
      wait_at(1);
      chk("comp in phase", 32'(clk_out.true_pin), 32'(clk_out.comp_pin));
    end
    wr(coa_pkg::REG_OUT_MODE, 32'h001F_FFD5);
    for (k = 0; k < 8; k++) begin
      wait_at(1);
      chk("comp inverted", 32'(clk_out.true_pin ^ 7'h7F), 32'(clk_out.comp_pin));
    end
    @(posedge clk) output_gate_pin_n <= 1'b1;
    wait_at(4);
    chk("async stop", 32'h55, 32'(clk_out.true_pin));
    wait_at(46);
    chk("gated rest", 32'h55, 32'(clk_out.true_pin));
    @(posedge clk) output_gate_pin_n <= 1'b0;
    // output 0 synchronous, resting low, so a cut high phase would show
    wr(coa_pkg::REG_OUT_MODE, 32'h001F_8054);
    wait_at(10);
    while (clk_out.true_pin[0] !== 1'b0) wait_at(1);
    while (clk_out.true_pin[0] !== 1'b1) wait_at(1);
    wr(coa_pkg::REG_OUT_DIS, 32'h1);
    wait_at(2);
    chk("sync disable waits", 32'h1, 32'(clk_out.true_pin[0]));
    wait_at(12);
    chk("sync disable rests", 32'h0, 32'(clk_out.true_pin[0]));
    wr(coa_pkg::REG_OUT_MODE, 32'h001F_FFD5);
    wait_at(8);
    k = load_edges;
    wait_at(40);
    chk("single off", 32'(k), 32'(load_edges));
    wr(coa_pkg::REG_OUT_DIS, 32'h0);
    @(posedge clk) crystal_ref_loss_alarm <= 1'b1;
    wait_at(8);
    chk("xtal loss rest", 32'h55, 32'(clk_out.true_pin));
    wr(coa_pkg::REG_CTRL, 32'h4);
    k = load_edges;
    wait_at(40);
    chk("xtal keep runs", 32'h1, 32'(load_edges > k));
    @(posedge clk) crystal_ref_loss_alarm <= 1'b0;
    wr(coa_pkg::REG_CTRL, 32'h2);
    @(posedge clk) status_raw.lock_loss_alarm[0] <= 1'b1;
    wait_at(8);
    chk("lol gated rest", 32'h2A, 32'(clk_out.true_pin[6:1]));
    k = load_edges;
    wait_at(40);
    chk("xpoint pll1 runs", 32'h1, 32'(load_edges > k));
    @(posedge clk) status_raw.lock_loss_alarm[0] <= 1'b0;
    wait_at(14);
    wr(coa_pkg::REG_STICKY, 32'hFFF);
    wr(coa_pkg::REG_CTRL, 32'h8);
    wait_at(8);
    k = load_edges;
    wait_at(40);
    chk("divider held", 32'(k), 32'(load_edges));
    wr(coa_pkg::REG_CTRL, 32'h0);
    $display("test outputs done");
  endtask
  task automatic t_pps();
    wr(coa_pkg::REG_PPS_THR, 32'h0100_0080);
    wr(coa_pkg::REG_PPS_CNT, 32'h0008_0006);
    wr(coa_pkg::REG_PHASE, 32'h1234);
    wr(coa_pkg::REG_CTRL, 32'h1);
    wait_at(20);
    chk("phase offset", 32'h1234, 32'(pps_phase_offset));
    chk("lock after clear", 32'h0, 32'(pps_pll_lock_loss_pin));
    @(posedge clk) pps_phase_err <= 16'h0200;
    repeat (5) @(posedge clk);
    pps_phase_err <= 16'h0;
    wait_at(12);
    chk("short burst", 32'h0, 32'(pps_pll_lock_loss_pin));
    @(posedge clk) pps_phase_err <= 16'h0200;
    k = 0;
    while (pps_pll_lock_loss_pin !== 1'b1 && k < 30) begin
      wait_at(1);
      k++;
    end
    chk("raise delay", 32'h1, 32'(k >= 8 && k <= 11));
    @(posedge clk) pps_phase_err <= 16'h00C0;
    wait_at(20);
    chk("between thresholds", 32'h1, 32'(pps_pll_lock_loss_pin));
    @(posedge clk) status_raw.lock_loss_alarm[2] <= 1'b1;
    wait_at(10);
    chk("pps pll not in intr", 32'h1, 32'(interrupt_out_n));
    @(posedge clk) status_raw.lock_loss_alarm[2] <= 1'b0;
    pps_phase_err <= 16'h0;
    wait_at(14);
    wr(coa_pkg::REG_STICKY, 32'hFFF);
    $display("test pps done");
  endtask
  task automatic t_misc();
    wr(coa_pkg::REG_PWR, 32'h1FFF);
    wait_at(3);
    chk("power down", 32'h1FFF, 32'(power_down));
    wr(coa_pkg::REG_CTRL, 32'h10);
    wait_at(3);
    chk("cascade on", 32'h1, 32'(cascade_active));
    chk("out6 kept up", 32'h1DFF, 32'(power_down));
    wr(coa_pkg::REG_BOOT, coa_pkg::BOOT_KEY);
    wait_at(3);
    chk("boot by key", 32'h1, 32'(bootloader_active));
    @(posedge clk);
    reset_load();
    reset_pin_n <= 1'b0;
    boot_mode_select_n <= 1'b0;
    wait_at(6);
    chk("boot cleared", 32'h0, 32'(bootloader_active));
    @(posedge clk) reset_pin_n <= 1'b1;
    wait_at(8);
    chk("boot by pin", 32'h1, 32'(bootloader_active));
    $display("test misc done");
  endtask
  initial begin
    {reg_wr, reg_rd, nvm_valid, crystal_ref_loss_alarm, output_gate_pin_n} = 5'h00;
    {reg_addr, reg_wdata, nvm_word, pps_phase_err, status_raw} = '0;
    {sys_rst, reset_pin_n, boot_mode_select_n} = 3'h7;
    reset_load();
    wait_at(4);
    chk("load done", 32'h1, 32'(nvm_load_done));
    chk("intr idle", 32'h1, 32'(interrupt_out_n));
    rd(8'hFC);
    chk("unmapped read", 32'h0, rd_q);
    rd(coa_pkg::REG_XPOINT);
    chk("nvm xpoint", 32'h1, rd_q);
    $display("test start done");
    t_intr();
    t_out();
    t_pps();
    t_misc();
    print_verdict();
  end
endmodule // test_clock_output_alarm_control

// >>> verilog/coa_pkg.sv
package coa_pkg;
  localparam int NUM_PLL = 3;
  localparam int NUM_OUT = 7;
  localparam int NUM_IND = 4;
  localparam int PPS_PLL = 2;
  localparam int OUT_CASCADE_SRC = 6;
  localparam int OUT_CASCADE_DST = 5;
  localparam int SEL_W = 2;
  localparam int PH_W = 16;
  localparam int CNT_W = 16;
  localparam int DIV_W = 16;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // register offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_PPS_THR = 8'h04;
  localparam logic [7:0] REG_PPS_CNT = 8'h08;
  localparam logic [7:0] REG_MASK = 8'h0C;
  localparam logic [7:0] REG_STICKY = 8'h10;
  localparam logic [7:0] REG_LIVE = 8'h14;
  localparam logic [7:0] REG_XPOINT = 8'h18;
  localparam logic [7:0] REG_OUT_DIS = 8'h1C;
  localparam logic [7:0] REG_OUT_MODE = 8'h20;
  localparam logic [7:0] REG_DIV0 = 8'h24;
  localparam logic [7:0] REG_PHASE = 8'h40;
  localparam logic [7:0] REG_PWR = 8'h44;
  localparam logic [7:0] REG_BOOT = 8'h48;

  // control bits
  localparam int CTRL_PPS_MODE = 0;
  localparam int CTRL_LOL_DIS = 1;
  localparam int CTRL_XLOS_KEEP = 2;
  localparam int CTRL_HARD_RST = 3;
  localparam int CTRL_CASCADE = 4;

  localparam logic [DATA_W-1:0] BOOT_KEY = 32'hB007_5EED;
  localparam logic [SEL_W-1:0] XPOINT_RST = 2'h0;
  localparam logic [DIV_W-1:0] DIV_RST = 16'h0001;
  // output 6 ceiling while cascading, in Hz
  localparam int CASCADE_MAX_HZ = 33_500_000;

  // status indicators per pll: los, oof, lol, hold
  typedef struct packed {
    logic [NUM_PLL-1:0] signal_loss_alarm;
    logic [NUM_PLL-1:0] oof;
    logic [NUM_PLL-1:0] lock_loss_alarm;
    logic [NUM_PLL-1:0] hold;
  } coa_status_t;

  typedef struct packed {
    logic [NUM_OUT-1:0] true_pin;
    logic [NUM_OUT-1:0] comp_pin;
  } coa_clk_out_t;
endpackage

// >>> verilog/coa_top.sv
`timescale 1ns/1ps
module coa_top #(
  parameter int NUM_PLL = coa_pkg::NUM_PLL,
  parameter int NUM_OUT = coa_pkg::NUM_OUT
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [coa_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [coa_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [coa_pkg::DATA_W-1:0] reg_rdata,
  input wire logic [coa_pkg::DATA_W-1:0] nvm_word,
  input wire logic nvm_valid,
  output logic nvm_load_done,
  input wire logic [coa_pkg::PH_W-1:0] pps_phase_err,
  input wire coa_pkg::coa_status_t status_raw,
  input wire logic crystal_ref_loss_alarm,
  input wire logic output_gate_pin_n,
  input wire logic reset_pin_n,
  input wire logic boot_mode_select_n,
  input wire logic [NUM_PLL-1:0] pll_clk,
  output coa_pkg::coa_clk_out_t clk_out,
  output logic interrupt_out_n,
  output logic pps_pll_lock_loss_pin,
  output logic bootloader_active,
  output logic [coa_pkg::PH_W-1:0] pps_phase_offset,
  output logic [NUM_PLL+NUM_OUT+NUM_PLL-1:0] power_down,
  output logic cascade_active
);
  localparam int IW = 4 * NUM_PLL;

  // pin synchronisers
  // reset and boot pins rest high, so they leave reset at their idle level;
  // a low reset value would look like a reset-pin release and could enter boot mode
  localparam logic [NUM_PLL+4+IW-1:0] SYNC_IDLE = {{(NUM_PLL+2){1'b0}}, 2'h3, {IW{1'b0}}};
  logic [NUM_PLL+4+IW-1:0] sync1_q, sync2_q;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sync1_q <= SYNC_IDLE;
      sync2_q <= SYNC_IDLE;
    end else begin
      sync1_q <= {pll_clk, crystal_ref_loss_alarm, output_gate_pin_n, reset_pin_n,
                  boot_mode_select_n, status_raw};
      sync2_q <= sync1_q;
    end
  end
  logic [NUM_PLL-1:0] pclk;
  logic xlos, gate_n, rpin_n, bootpin_n;
  coa_pkg::coa_status_t st;
  assign {pclk, xlos, gate_n, rpin_n, bootpin_n, st} = sync2_q;

  // registers
  logic [4:0] ctrl_q;
  logic [2*coa_pkg::PH_W-1:0] thr_q;
  logic [2*coa_pkg::CNT_W-1:0] cnt_cfg_q;
  logic [IW-1:0] mask_q, sticky_q, live_prev_q;
  logic [coa_pkg::SEL_W*NUM_OUT-1:0] xp_q;
  logic [NUM_OUT-1:0] odis_q, rest_q, async_q, inv_q;
  logic [coa_pkg::DIV_W-1:0] div_cfg_q [NUM_OUT];
  logic [coa_pkg::PH_W-1:0] phase_q;
  logic [2*NUM_PLL+NUM_OUT-1:0] pwr_q;
  logic boot_q, rpin_prev_q, loading_q;
  logic [3:0] load_idx_q;
  logic pps_lol_q;

  wire pps_mode = ctrl_q[coa_pkg::CTRL_PPS_MODE];
  // writes are dropped during preload so the stored defaults are never half overwritten
  wire wr_ok = reg_wr & ~loading_q;

  // default load from nonvolatile store before normal operation
  // three words in fixed order: crosspoint, control with mask, output modes
  // nvm preload
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      loading_q <= 1'b1;
      load_idx_q <= '0;
    end else if (loading_q && nvm_valid) begin
      load_idx_q <= load_idx_q + 4'h1;
      if (load_idx_q == 4'h2) loading_q <= 1'b0;
    end
  end
  assign nvm_load_done = ~loading_q;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      xp_q <= {NUM_OUT{coa_pkg::XPOINT_RST}};
    end else if (loading_q && nvm_valid && load_idx_q == 4'h0) begin
      xp_q <= nvm_word[coa_pkg::SEL_W*NUM_OUT-1:0];
    end else if (wr_ok && reg_addr == coa_pkg::REG_XPOINT) begin
      xp_q <= reg_wdata[coa_pkg::SEL_W*NUM_OUT-1:0];
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_q <= '0;
      thr_q <= '0;
      cnt_cfg_q <= '0;
      mask_q <= '0;
      odis_q <= '0;
      rest_q <= '0;
      async_q <= '0;
      inv_q <= '0;
      phase_q <= '0;
      pwr_q <= '0;
    end else if (loading_q && nvm_valid && load_idx_q == 4'h1) begin
      ctrl_q <= nvm_word[4:0];
      mask_q <= nvm_word[31:32-IW];
    end else if (loading_q && nvm_valid && load_idx_q == 4'h2) begin
      {async_q, inv_q, rest_q} <= nvm_word[3*NUM_OUT-1:0];
    end else if (wr_ok) begin
      case (reg_addr)
        coa_pkg::REG_CTRL: ctrl_q <= reg_wdata[4:0];
        coa_pkg::REG_PPS_THR: thr_q <= reg_wdata;
        coa_pkg::REG_PPS_CNT: cnt_cfg_q <= reg_wdata;
        coa_pkg::REG_MASK: mask_q <= reg_wdata[IW-1:0];
        coa_pkg::REG_OUT_DIS: odis_q <= reg_wdata[NUM_OUT-1:0];
        coa_pkg::REG_OUT_MODE: {async_q, inv_q, rest_q} <= reg_wdata[3*NUM_OUT-1:0];
        coa_pkg::REG_PHASE: phase_q <= reg_wdata[coa_pkg::PH_W-1:0];
        coa_pkg::REG_PWR: pwr_q <= reg_wdata[2*NUM_PLL+NUM_OUT-1:0];
        default: ;
      endcase
    end
  end

  // divider config held at known value under reset
  genvar g;
  generate
    for (g = 0; g < NUM_OUT; g++) begin : g_divcfg
      always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
          div_cfg_q[g] <= coa_pkg::DIV_RST;
        end else if (wr_ok && reg_addr == coa_pkg::REG_DIV0 + 8'(4 * g)) begin
          div_cfg_q[g] <= reg_wdata[coa_pkg::DIV_W-1:0];
        end
      end
    end
  endgenerate

  // pps lock monitor
  logic [coa_pkg::CNT_W-1:0] raise_cnt_q, clear_cnt_q;
  wire [coa_pkg::PH_W-1:0] raise_thr = thr_q[2*coa_pkg::PH_W-1:coa_pkg::PH_W];
  wire [coa_pkg::PH_W-1:0] clear_thr = thr_q[coa_pkg::PH_W-1:0];
  wire [coa_pkg::CNT_W-1:0] raise_need = cnt_cfg_q[2*coa_pkg::CNT_W-1:coa_pkg::CNT_W];
  wire [coa_pkg::CNT_W-1:0] clear_need = cnt_cfg_q[coa_pkg::CNT_W-1:0];
  // phase error arrives on this clock from the pll core, no sync needed
  // phase thresholds
  wire over_raise = pps_phase_err > raise_thr;
  wire under_clear = pps_phase_err < clear_thr;
  // the alarm starts raised, so lock must be proven before the pin clears
  // consecutive counters
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      raise_cnt_q <= '0;
      clear_cnt_q <= '0;
      pps_lol_q <= 1'b1;
    end else if (!pps_mode) begin
      raise_cnt_q <= '0;
      clear_cnt_q <= '0;
      pps_lol_q <= 1'b1;
    end else begin
      raise_cnt_q <= (over_raise && !pps_lol_q) ? raise_cnt_q + 1'b1 : '0;
      clear_cnt_q <= (under_clear && pps_lol_q) ? clear_cnt_q + 1'b1 : '0;
      if (!pps_lol_q && over_raise && raise_cnt_q + 1'b1 >= raise_need) pps_lol_q <= 1'b1;
      if (pps_lol_q && under_clear && clear_cnt_q + 1'b1 >= clear_need) pps_lol_q <= 1'b0;
    end
  end
  assign pps_pll_lock_loss_pin = pps_mode & pps_lol_q;

  // status live/sticky
  logic [IW-1:0] live, excl;
  always_comb begin
    live = st;
    excl = '0;
    if (pps_mode) begin
      for (int k = 0; k < 4; k++) excl[k*NUM_PLL+coa_pkg::PPS_PLL] = 1'b1;
    end
  end
  wire [IW-1:0] change = (live ^ live_prev_q) & ~excl;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      live_prev_q <= '0;
      sticky_q <= '0;
    end else begin
      live_prev_q <= live;
      sticky_q <= (sticky_q & ~((wr_ok && reg_addr == coa_pkg::REG_STICKY) ?
                   reg_wdata[IW-1:0] : '0)) | change;
    end
  end
  // registered so the pin cannot glitch while sticky and mask bits change together
  // active low interrupt; held till cleared; masking
  logic int_n_q;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) int_n_q <= 1'b1;
    else int_n_q <= ~|(sticky_q & ~mask_q & ~excl);
  end
  assign interrupt_out_n = int_n_q;

  // bootloader entry
  // boot pin at reset release or key write
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      boot_q <= 1'b0;
      rpin_prev_q <= 1'b1;
    end else begin
      rpin_prev_q <= rpin_n;
      if (rpin_n && !rpin_prev_q && !bootpin_n) boot_q <= 1'b1;
      if (wr_ok && reg_addr == coa_pkg::REG_BOOT && reg_wdata == coa_pkg::BOOT_KEY)
        boot_q <= 1'b1;
    end
  end
  assign bootloader_active = boot_q;

  // holding every divider at zero restarts all outputs in phase
  // divider reset sources
  wire div_rst = loading_q | ~rpin_n | ctrl_q[coa_pkg::CTRL_HARD_RST];
  // output 6 shows as powered on power_down while it feeds output 5; its pin gating still follows pwr_q
  // cascade needs output 6 powered
  wire cascade = ctrl_q[coa_pkg::CTRL_CASCADE];
  assign cascade_active = cascade;
  always_comb begin
    power_down = pwr_q;
    if (cascade) power_down[NUM_PLL+coa_pkg::OUT_CASCADE_SRC] = 1'b0;
  end
  // the offset only means something in pps mode, so it reads zero otherwise
  assign pps_phase_offset = pps_mode ? phase_q : '0;

  // output dividers and gating
  logic [coa_pkg::DIV_W-1:0] div_cnt_q [NUM_OUT];
  logic [NUM_OUT-1:0] div_out_q, en_q, pclk_prev_q, tp_q, cp_q;
  logic [NUM_OUT-1:0] src_edge, want_en;
  logic [coa_pkg::SEL_W-1:0] sel [NUM_OUT];
  logic [NUM_OUT-1:0] phase_hold;
  always_comb begin
    for (int o = 0; o < NUM_OUT; o++) begin
      sel[o] = xp_q[coa_pkg::SEL_W*o +: coa_pkg::SEL_W];
      // an unused crosspoint code falls back to the first pll instead of an unknown clock
      if (sel[o] >= coa_pkg::SEL_W'(NUM_PLL)) begin
        sel[o] = '0;
      end
      src_edge[o] = pclk[sel[o]] & ~pclk_prev_q[o];
      // output 6 divider feeds output 5
      if (cascade && o == coa_pkg::OUT_CASCADE_DST)
        src_edge[o] = div_out_q[coa_pkg::OUT_CASCADE_SRC] & ~pclk_prev_q[o];
      // gate pin; register; crystal loss; lock loss
      want_en[o] = ~gate_n & ~odis_q[o] & ~pwr_q[NUM_PLL+o]
                   & ~(xlos & ~ctrl_q[coa_pkg::CTRL_XLOS_KEEP])
                   & ~(ctrl_q[coa_pkg::CTRL_LOL_DIS] & ~pps_mode & st.lock_loss_alarm[sel[o]]);
      // hold pps outputs while phase offset not yet reached
      phase_hold[o] = pps_mode && sel[o] == coa_pkg::SEL_W'(coa_pkg::PPS_PLL)
                      && div_cnt_q[o] < phase_q[coa_pkg::DIV_W-1:0] && div_out_q[o] == 1'b0;
    end
  end

  generate
    for (g = 0; g < NUM_OUT; g++) begin : g_out
      always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
          div_cnt_q[g] <= '0;
          div_out_q[g] <= 1'b0;
          pclk_prev_q[g] <= 1'b0;
        end else begin
          pclk_prev_q[g] <= (cascade && g == coa_pkg::OUT_CASCADE_DST) ?
                            div_out_q[coa_pkg::OUT_CASCADE_SRC] : pclk[sel[g]];
          if (div_rst) begin
            div_cnt_q[g] <= '0;
            div_out_q[g] <= 1'b0;
          end else if (src_edge[g] && !phase_hold[g]) begin
            if (div_cnt_q[g] + 1'b1 >= div_cfg_q[g]) begin
              div_cnt_q[g] <= '0;
              div_out_q[g] <= ~div_out_q[g];
            end else begin
              div_cnt_q[g] <= div_cnt_q[g] + 1'b1;
            end
          end else if (src_edge[g]) begin
            div_cnt_q[g] <= div_cnt_q[g] + 1'b1;
          end
        end
      end
      always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
          en_q[g] <= 1'b0;
        end else if (want_en[g]) begin
          en_q[g] <= 1'b1;
        end else if (async_q[g]) begin
          en_q[g] <= 1'b0;
        end else if (div_out_q[g] == 1'b0) begin
          en_q[g] <= 1'b0;
        end
      end
      always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
          tp_q[g] <= 1'b0;
          cp_q[g] <= 1'b0;
        end else if (en_q[g] && (want_en[g] || !async_q[g])) begin
          tp_q[g] <= div_out_q[g];
          cp_q[g] <= div_out_q[g] ^ inv_q[g];
        end else begin
          tp_q[g] <= rest_q[g];
          cp_q[g] <= rest_q[g] ^ inv_q[g];
        end
      end
    end
  endgenerate
  // pins come straight from flops; a gate-off cuts a level mid-cycle only with async_q set, synchronous ones wait for a low level; a gate-on never waits
  assign clk_out.true_pin = tp_q;
  assign clk_out.comp_pin = cp_q;

  // register reads
  // read data is zero outside its answer cycle, so a stale value is never taken
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      case (reg_addr)
        coa_pkg::REG_CTRL: reg_rdata <= 32'(ctrl_q);
        coa_pkg::REG_PPS_THR: reg_rdata <= thr_q;
        coa_pkg::REG_PPS_CNT: reg_rdata <= cnt_cfg_q;
        coa_pkg::REG_MASK: reg_rdata <= 32'(mask_q);
        coa_pkg::REG_STICKY: reg_rdata <= 32'(sticky_q);
        coa_pkg::REG_LIVE: reg_rdata <= 32'({pps_lol_q, live});
        coa_pkg::REG_XPOINT: reg_rdata <= 32'(xp_q);
        coa_pkg::REG_OUT_DIS: reg_rdata <= 32'({en_q, odis_q});
        coa_pkg::REG_OUT_MODE: reg_rdata <= 32'({async_q, inv_q, rest_q});
        coa_pkg::REG_PHASE: reg_rdata <= 32'(phase_q);
        coa_pkg::REG_PWR: reg_rdata <= 32'(pwr_q);
        coa_pkg::REG_BOOT: reg_rdata <= 32'({nvm_load_done, boot_q});
        default: reg_rdata <= '0;
      endcase
    end else begin
      reg_rdata <= '0;
    end
  end
endmodule // coa_top
